// ===== hdl/crl_map.vh
`ifndef CRL_MAP_VH
`define CRL_MAP_VH

// System clock rate in MHz
`define CRL_CLK_MHZ          100
// Least reset hold time in ms
`define CRL_RESET_HOLD_MS    50
`define CRL_RESET_HOLD_CYCLES (`CRL_RESET_HOLD_MS * 1000 * `CRL_CLK_MHZ)
// Shift clock half period in ns
`define CRL_HALF_PERIOD_NS   200
`define CRL_HALF_CYCLES      ((`CRL_HALF_PERIOD_NS * `CRL_CLK_MHZ + 999) / 1000)
// Bits in one control word
`define CRL_WORD_BITS        16
// Level of the reset and select pins
`define CRL_RESET_ACTIVE     1'b0
`define CRL_RESET_IDLE       1'b1
`define CRL_SELECT_ENABLE    1'b0
`define CRL_SELECT_LOCK      1'b1
// Dummy control word value
`define CRL_DUMMY_WORD       16'h0000

`endif

// ===== hdl/crl_set_shifter.v
`timescale 1ns/1ps
`include "crl_map.vh"

// Shifts one control set (upper then lower word) out on the serial pins
module crl_set_shifter #(
	parameter WORD_BITS = `CRL_WORD_BITS
) (
	input  wire                 clk_in,
	input  wire                 rst_in,
	input  wire                 tick_in,
	input  wire                 go_in,
	input  wire [WORD_BITS-1:0] upper_word_in,
	input  wire [WORD_BITS-1:0] lower_word_in,
	output reg                  select_n_out,
	output reg                  shift_clock_out,
	output reg                  serial_data_out,
	output wire                 busy_out,
	output reg                  done_out
);
	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_SEL   = 6'h02;
	localparam [5:0] ST_RAISE = 6'h04;
	localparam [5:0] ST_DRIVE = 6'h08;
	localparam [5:0] ST_LOWER = 6'h10;
	localparam [5:0] ST_FIN   = 6'h20;
	localparam integer LAST_BIT_INT = 2 * WORD_BITS - 1;
	localparam [7:0]   LAST_BIT     = LAST_BIT_INT[7:0];

	reg [5:0]             state;
	reg [2*WORD_BITS-1:0] sreg;
	reg [7:0]             count;

	assign busy_out = (state != ST_IDLE);

	always @(posedge clk_in) begin
		if (rst_in) begin
			state           <= ST_IDLE;
			sreg            <= {2*WORD_BITS{1'b0}};
			count           <= 8'h00;
			select_n_out    <= `CRL_SELECT_LOCK;
			shift_clock_out <= 1'b0;
			serial_data_out <= 1'b0;
			done_out        <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (go_in) begin
						sreg         <= {upper_word_in, lower_word_in};
						count        <= 8'h00;
						select_n_out <= `CRL_SELECT_ENABLE;
						state        <= ST_SEL;
					end
				end
				ST_SEL: begin
					if (tick_in)
						state <= ST_RAISE;
				end
				ST_RAISE: begin
					if (tick_in) begin
						shift_clock_out <= 1'b1;
						state           <= ST_DRIVE;
					end
				end
				ST_DRIVE: begin
					serial_data_out <= sreg[2*WORD_BITS-1];
					state           <= ST_LOWER;
				end
				ST_LOWER: begin
					if (tick_in) begin
						shift_clock_out <= 1'b0;
						sreg            <= {sreg[2*WORD_BITS-2:0], 1'b0};
						count           <= count + 8'h01;
						if (count == LAST_BIT)
							state <= ST_FIN;
						else
							state <= ST_RAISE;
					end
				end
				ST_FIN: begin
					if (tick_in) begin
						select_n_out <= `CRL_SELECT_LOCK;
						done_out     <= 1'b1;
						state        <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // crl_set_shifter

// ===== hdl/crl_codec_loader.v
`timescale 1ns/1ps
`include "crl_map.vh"

// Host sequencer: resets the converter, sends a dummy set, then the real set
module crl_codec_loader #(
	parameter        WORD_BITS         = `CRL_WORD_BITS,
	parameter [31:0] RESET_HOLD_CYCLES = `CRL_RESET_HOLD_CYCLES,
	parameter [15:0] HALF_CYCLES       = `CRL_HALF_CYCLES
) (
	input  wire                 clk_in,
	input  wire                 rst_in,
	input  wire                 reset_req_in,
	input  wire                 load_req_in,
	input  wire [WORD_BITS-1:0] upper_control_word_in,
	input  wire [WORD_BITS-1:0] lower_control_word_in,
	input  wire                 frame_sync_in,
	input  wire                 audio_bit_clock_in,
	output reg                  converter_reset_n_out,
	output reg                  control_select_n_out,
	output reg                  control_shift_clock_out,
	output reg                  control_serial_in_out,
	output wire                 busy_out,
	output reg                  ready_out,
	output reg                  load_done_out,
	output reg                  frame_start_out,
	output reg                  audio_capture_out,
	output reg                  audio_launch_out
);
	localparam [5:0] ST_HOLD    = 6'h01;
	localparam [5:0] ST_RELEASE = 6'h02;
	localparam [5:0] ST_DUMMY   = 6'h04;
	localparam [5:0] ST_REAL    = 6'h08;
	localparam [5:0] ST_WAIT    = 6'h10;
	localparam [5:0] ST_IDLE    = 6'h20;

	localparam [31:0] HOLD_LAST = RESET_HOLD_CYCLES - 32'h00000001;
	localparam [15:0] HALF_LAST = HALF_CYCLES - 16'h0001;

	reg  [5:0]           state;
	reg  [31:0]          hold_cnt;
	reg  [15:0]          div_cnt;
	reg                  tick;
	reg                  go;
	reg                  use_dummy;
	reg  [WORD_BITS-1:0] upper_hold;
	reg  [WORD_BITS-1:0] lower_hold;
	wire [WORD_BITS-1:0] shift_upper;
	wire [WORD_BITS-1:0] shift_lower;
	wire                 sh_select_n;
	wire                 sh_clock;
	wire                 sh_data;
	wire                 sh_busy;
	wire                 sh_done;

	// Audio pin samplers
	reg                  frame_sync_meta;
	reg                  frame_sync_sync;
	reg                  frame_sync_last;
	reg                  bclk_meta;
	reg                  bclk_sync;
	reg                  bclk_last;

	assign busy_out    = (state != ST_IDLE);
	assign shift_upper = use_dummy ? `CRL_DUMMY_WORD : upper_hold;
	assign shift_lower = use_dummy ? `CRL_DUMMY_WORD : lower_hold;

	// Half period enable for the shift clock
	always @(posedge clk_in) begin
		if (rst_in) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (div_cnt == HALF_LAST) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

	// Reset and load sequencer
	always @(posedge clk_in) begin
		if (rst_in) begin
			state         <= ST_HOLD;
			hold_cnt      <= 32'h00000000;
			go            <= 1'b0;
			use_dummy     <= 1'b1;
			upper_hold    <= {WORD_BITS{1'b0}};
			lower_hold    <= {WORD_BITS{1'b0}};
			ready_out     <= 1'b0;
			load_done_out <= 1'b0;
		end else begin
			go            <= 1'b0;
			load_done_out <= 1'b0;
			case (state)
				ST_HOLD: begin
					ready_out <= 1'b0;
					use_dummy <= 1'b1;
					if (hold_cnt == HOLD_LAST) begin
						hold_cnt <= 32'h00000000;
						state    <= ST_RELEASE;
					end else begin
						hold_cnt <= hold_cnt + 32'h00000001;
					end
				end
				ST_RELEASE: begin
					// Reset pin goes high one cycle after entering here, before any bit moves
					if (tick) begin
						upper_hold <= upper_control_word_in;
						lower_hold <= lower_control_word_in;
						go         <= 1'b1;
						state      <= ST_DUMMY;
					end
				end
				ST_DUMMY: begin
					if (sh_done) begin
						use_dummy <= 1'b0;
						go        <= 1'b1;
						state     <= ST_REAL;
					end
				end
				ST_REAL: begin
					if (sh_done) begin
						load_done_out <= 1'b1;
						ready_out     <= 1'b1;
						state         <= ST_IDLE;
					end
				end
				ST_WAIT: begin
					if (sh_done) begin
						load_done_out <= 1'b1;
						ready_out     <= 1'b1;
						state         <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (reset_req_in) begin
						hold_cnt <= 32'h00000000;
						state    <= ST_HOLD;
					end else if (load_req_in) begin
						upper_hold <= upper_control_word_in;
						lower_hold <= lower_control_word_in;
						ready_out  <= 1'b0;
						go         <= 1'b1;
						state      <= ST_WAIT;
					end
				end
				default: state <= ST_HOLD;
			endcase
		end
	end

	crl_set_shifter #(
		.WORD_BITS      (WORD_BITS)
	) u_shifter (
		.clk_in         (clk_in),
		.rst_in         (rst_in),
		.tick_in        (tick),
		.go_in          (go),
		.upper_word_in  (shift_upper),
		.lower_word_in  (shift_lower),
		.select_n_out   (sh_select_n),
		.shift_clock_out(sh_clock),
		.serial_data_out(sh_data),
		.busy_out       (sh_busy),
		.done_out       (sh_done)
	);

	// Pin drivers
	always @(posedge clk_in) begin
		if (rst_in) begin
			converter_reset_n_out   <= `CRL_RESET_ACTIVE;
			control_select_n_out    <= `CRL_SELECT_ENABLE;
			control_shift_clock_out <= 1'b0;
			control_serial_in_out   <= 1'b0;
		end else begin
			if (state == ST_HOLD)
				converter_reset_n_out <= `CRL_RESET_ACTIVE;
			else
				converter_reset_n_out <= `CRL_RESET_IDLE;
			if (state == ST_HOLD)
				control_select_n_out <= `CRL_SELECT_ENABLE;
			else if (sh_busy)
				control_select_n_out <= sh_select_n;
			else
				control_select_n_out <= `CRL_SELECT_LOCK;
			// Converter samples data on the falling shift clock edge
			control_shift_clock_out <= sh_clock;
			control_serial_in_out   <= sh_data;
		end
	end

	// Frame sync and bit clock edge finders
	always @(posedge clk_in) begin
		if (rst_in) begin
			frame_sync_meta        <= 1'b0;
			frame_sync_sync        <= 1'b0;
			frame_sync_last        <= 1'b0;
			bclk_meta         <= 1'b0;
			bclk_sync         <= 1'b0;
			bclk_last         <= 1'b0;
			frame_start_out   <= 1'b0;
			audio_capture_out <= 1'b0;
			audio_launch_out  <= 1'b0;
		end else begin
			frame_sync_meta        <= frame_sync_in;
			frame_sync_sync        <= frame_sync_meta;
			frame_sync_last        <= frame_sync_sync;
			bclk_meta         <= audio_bit_clock_in;
			bclk_sync         <= bclk_meta;
			bclk_last         <= bclk_sync;
			frame_start_out   <= frame_sync_sync & ~frame_sync_last;
			audio_capture_out <= bclk_sync & ~bclk_last;
			audio_launch_out  <= ~bclk_sync & bclk_last;
		end
	end
endmodule // crl_codec_loader

// ===== verification/crl_conv_model.sv
`timescale 1ns/1ps
// Converter side: keeps the last complete control set it accepted
module crl_conv_model (
	input  wire        reset_n_in,
	input  wire        select_n_in,
	input  wire        shift_clock_in,
	input  wire        serial_in,
	output reg  [31:0] set_out,
	output reg  [3:0]  taken_out
);
	reg [31:0] shift;
	reg [5:0]  count;
	reg        first;
	initial begin
		set_out   = 32'h0;
		taken_out = 4'h0;
		count     = 6'h0;
		first     = 1'b1;
	end
	// Host launches the bit after the rise, so the bit is taken on the falling clock edge
	always @(negedge shift_clock_in or posedge select_n_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= 6'h0;
			first <= 1'b1;
		end else if (select_n_in) begin
			if (count == 6'h20 && first)
				first <= 1'b0;
			else if (count == 6'h20) begin
				set_out   <= shift;
				taken_out <= taken_out + 4'h1;
			end
			count <= 6'h0;
		end else begin
			shift <= {shift[30:0], serial_in};
			count <= count + 6'h1;
		end
	end
endmodule // crl_conv_model

// ===== verification/crl_codec_loader_properties.sv
`timescale 1ns/1ps
module crl_codec_loader_props #(
	parameter        WORD_BITS         = 16,
	parameter [31:0] RESET_HOLD_CYCLES = 32'h32,
	parameter [15:0] HALF_CYCLES       = 16'h4
) (
	input wire clk_in,
	input wire rst_in,
	input wire frame_sync_in,
	input wire audio_bit_clock_in,
	input wire converter_reset_n_out,
	input wire control_select_n_out,
	input wire control_shift_clock_out,
	input wire control_serial_in_out,
	input wire ready_out,
	input wire load_done_out,
	input wire frame_start_out,
	input wire audio_capture_out,
	input wire audio_launch_out
);
	reg [31:0] low_len;
	reg [15:0] high_len;
	reg [7:0]  rises;
	always @(posedge clk_in) begin
		if (rst_in) begin
			low_len  <= 32'h0;
			high_len <= 16'h0;
			rises    <= 8'h0;
		end else begin
			low_len  <= converter_reset_n_out ? 32'h0 : low_len + 32'h1;
			high_len <= control_shift_clock_out ? high_len + 16'h1 : 16'h0;
			rises    <= control_select_n_out ? 8'h0 : rises + {7'h0, $rose(control_shift_clock_out)};
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_rise;
		!control_shift_clock_out ##1 control_shift_clock_out;
	endsequence
	sequence s_high3;
		control_shift_clock_out [*3];
	endsequence
	chk_reset_hold: assert property ($rose(converter_reset_n_out) |-> low_len >= RESET_HOLD_CYCLES)
		else $error("reset released early");
	chk_select_in_reset: assert property (!converter_reset_n_out |-> !control_select_n_out)
		else $error("select high in reset");
	chk_no_shift_reset: assert property (!converter_reset_n_out |-> !control_shift_clock_out)
		else $error("shift clock in reset");
	chk_select_low_rise: assert property (s_rise |-> $past(control_select_n_out) == 1'b0)
		else $error("rise without select");
	chk_data_hold: assert property (s_high3 |-> $stable(control_serial_in_out))
		else $error("data moved while high");
	chk_half_period: assert property ($fell(control_shift_clock_out) |-> high_len == HALF_CYCLES)
		else $error("bad high time");
	chk_bits_per_set: assert property ($rose(control_select_n_out) && rises != 8'h0 |-> rises == 2 * WORD_BITS)
		else $error("bad bit count");
	chk_lock_done: assert property (load_done_out |-> $rose(control_select_n_out) && ready_out)
		else $error("done without lock");
	chk_frame_start: assert property ($rose(frame_sync_in) |-> ##[1:5] frame_start_out)
		else $error("frame start missing");
	chk_bit_capture: assert property ($rose(audio_bit_clock_in) |-> ##[1:5] audio_capture_out)
		else $error("capture missing");
	chk_bit_launch: assert property ($fell(audio_bit_clock_in) |-> ##[1:5] audio_launch_out)
		else $error("launch missing");
endmodule // crl_codec_loader_props

bind crl_codec_loader crl_codec_loader_props #(
	.WORD_BITS(WORD_BITS),
	.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
	.HALF_CYCLES(HALF_CYCLES)
) u_crl_codec_loader_props (
	.clk_in, .rst_in, .frame_sync_in, .audio_bit_clock_in, .converter_reset_n_out,
	.control_select_n_out, .control_shift_clock_out, .control_serial_in_out, .ready_out,
	.load_done_out, .frame_start_out, .audio_capture_out, .audio_launch_out
);

// ===== verification/tb_crl_codec_loader.sv
`timescale 1ns/1ps
module tb_crl_codec_loader;
	reg         clk_in = 1'b0;
	reg         rst_in = 1'b1;
	reg         reset_req_in = 1'b0;
	reg         load_req_in = 1'b0;
	reg  [15:0] upper_control_word_in = 16'ha5c3;
	reg  [15:0] lower_control_word_in = 16'h3c5a;
	reg         frame_sync_in = 1'b0;
	reg         audio_bit_clock_in = 1'b0;
	reg         run = 1'b0;
	wire        converter_reset_n_out, control_select_n_out, control_shift_clock_out;
	wire        control_serial_in_out, ready_out, load_done_out, busy_out;
	wire        frame_start_out, audio_capture_out, audio_launch_out;
	wire [31:0] set_seen;
	wire [3:0]  taken;
	integer     fail_count = 0;
	integer     cmp_count = 0;
	integer     phase = 0;
	crl_codec_loader #(.RESET_HOLD_CYCLES(32'h32), .HALF_CYCLES(16'h4)) u_crl_codec_loader (
		.clk_in, .rst_in, .reset_req_in, .load_req_in, .upper_control_word_in,
		.lower_control_word_in, .frame_sync_in, .audio_bit_clock_in, .converter_reset_n_out,
		.control_select_n_out, .control_shift_clock_out, .control_serial_in_out, .busy_out,
		.ready_out, .load_done_out, .frame_start_out, .audio_capture_out, .audio_launch_out
	);
	crl_conv_model u_crl_conv_model (
		.reset_n_in(converter_reset_n_out), .select_n_in(control_select_n_out),
		.shift_clock_in(control_shift_clock_out), .serial_in(control_serial_in_out),
		.set_out(set_seen), .taken_out(taken)
	);
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// Audio pins: 80 ns bit clock, slower frame sync
	always @(posedge clk_in) begin
		phase <= phase + 1;
		if (run && phase % 4 == 0)
			audio_bit_clock_in <= #1 ~audio_bit_clock_in;
		if (run && phase % 32 == 0)
			frame_sync_in <= #1 ~frame_sync_in;
	end
	task give_verdict;
		begin
			$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task check(input string what, input [31:0] exp, input [31:0] got);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task wait_done;
		integer i;
		begin
			i = 0;
			while (load_done_out !== 1'b1 && i < 3000) begin
				@(posedge clk_in);
				#2;
				i = i + 1;
			end
			if (load_done_out !== 1'b1) begin
				check("load done", 32'h1, 32'h0);
				give_verdict;
			end
		end
	endtask
	task send(input rr, input [15:0] up, input [15:0] lo);
		begin
			@(posedge clk_in);
			#1;
			upper_control_word_in = up;
			lower_control_word_in = lo;
			reset_req_in = rr;
			load_req_in = ~rr;
			@(posedge clk_in);
			#1;
			reset_req_in = 1'b0;
			load_req_in = 1'b0;
		end
	endtask
	task t_powerup;
		begin
			wait_done;
			check("sets kept", 32'h1, {28'h0, taken});
			check("set", 32'ha5c33c5a, set_seen);
			check("reset pin", 32'h1, {31'h0, converter_reset_n_out});
			check("ready", 32'h1, {31'h0, ready_out});
			check("busy", 32'h0, {31'h0, busy_out});
		end
	endtask
	task t_load;
		begin
			send(1'b0, 16'h8000, 16'h0001);
			check("busy", 32'h1, {31'h0, busy_out});
			check("ready", 32'h0, {31'h0, ready_out});
			wait_done;
			check("sets kept", 32'h2, {28'h0, taken});
			check("set", 32'h80000001, set_seen);
			send(1'b0, 16'hffff, 16'h0000);
			// Second request lands while busy and must be dropped
			send(1'b0, 16'h1111, 16'h2222);
			wait_done;
			repeat (400) @(posedge clk_in);
			check("sets kept", 32'h3, {28'h0, taken});
			check("set", 32'hffff0000, set_seen);
		end
	endtask
	task t_rereset;
		begin
			send(1'b1, 16'h1234, 16'hfedc);
			repeat (2) @(posedge clk_in);
			#2;
			check("reset pin", 32'h0, {31'h0, converter_reset_n_out});
			check("select", 32'h0, {31'h0, control_select_n_out});
			wait_done;
			check("sets kept", 32'h4, {28'h0, taken});
			check("set", 32'h1234fedc, set_seen);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		run = 1'b1;
		t_powerup;
		t_load;
		t_rereset;
		give_verdict;
	end
endmodule // tb_crl_codec_loader
